// file: rtl/slwk_pkg.sv
// Package of constants for the sleep wake-up logic
`default_nettype none
package slwk_pkg;
    localparam int          PC_W            = 21;
    localparam int          SP_W            = 5;
    localparam int          INT_W           = 8;
    // Control register offsets
    localparam logic [3:0]  ADDR_WDOG_CTRL  = 4'h0;
    localparam logic [3:0]  ADDR_INT_CTRL   = 4'h1;
    localparam logic [3:0]  ADDR_PER_REQ    = 4'h2;
    localparam logic [3:0]  ADDR_STACK_TOP  = 4'h3;
    localparam logic [3:0]  ADDR_STACK_PTR  = 4'h4;
    localparam logic [3:0]  ADDR_PC         = 4'h5;
    localparam logic [3:0]  ADDR_STATUS     = 4'h6;
    // Watchdog control register fields
    localparam int          BIT_SINK        = 0;
    localparam int          BIT_MOD_EN      = 1;
    localparam int          BIT_WAKE_LVL    = 5;
    // Interrupt control fields
    localparam int          BIT_GIE_LOW     = 6;
    localparam int          BIT_GIE_HIGH    = 7;
    // Vectors, reset values and PC step
    localparam logic [20:0] VEC_HIGH        = 21'h00_0008;
    localparam logic [20:0] VEC_LOW         = 21'h00_0018;
    localparam logic [7:0]  WDOG_RST        = 8'h00;
    localparam logic [7:0]  INT_RST         = 8'h00;
    localparam logic [20:0] PC_RST          = 21'h00_0000;
    localparam logic [4:0]  SP_RST          = 5'h00;
    localparam logic [20:0] PC_STEP         = 21'h00_0002;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP} slwk_state_e;
endpackage
`default_nettype wire

// file: rtl/slwk_sleep_wake.sv
// Sleep wake-up logic: low-power pin wake and interrupt wake paths
// Functional notes
// - Armed wake module raises wake on slow pin fall, no extra current.
// - Enable and sink bits both set start discharge; device sinks the pin.
// - Pin below threshold during sleep wakes core at next instruction.
// - Wake by this module sets wake-level flag, control bit 5.
// - Interrupt wake with a global enable pushes PC + 2 into stack top.
// - Same case advances the stack pointer to the next location.
// - Same case loads PC with the high or low interrupt vector.
// - Interrupt wake leaves the causing source request flag set.
`default_nettype none
module slwk_sleep_wake
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        sleep_cmd,
    input  wire logic        pin_below_thresh,
    input  wire logic [7:0]  int_req,
    input  wire logic        int_high_prio,
    output logic             pin_sink_oe,
    output logic             pin_sink_out,
    output logic             sleeping,
    output logic             wake_pulse,
    output logic [20:0]      prog_counter
);
    ////////////////////////////////////////////////////////////////////
    slwk_pkg::slwk_state_e   state_r, state_nxt;
    logic [7:0]              wdog_r, wdog_nxt;
    logic [7:0]              intc_r, intc_nxt;
    logic [7:0]              preq_r, preq_nxt;
    logic [20:0]             tos_r, tos_nxt;
    logic [4:0]              sp_r, sp_nxt;
    logic [20:0]             pc_r, pc_nxt;
    logic [7:0]              rdata_r, rdata_nxt;
    logic                    wake_r, wake_nxt;
    logic                    armed;
    logic                    pin_wake;
    logic                    int_wake;
    logic                    gie_any;

    function automatic logic sel(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction

    assign armed    = wdog_r[slwk_pkg::BIT_MOD_EN] &
                      wdog_r[slwk_pkg::BIT_SINK];
    // Comparator only counts while armed, so no idle current
    assign pin_wake = armed & pin_below_thresh;
    assign int_wake = |int_req;
    assign gie_any  = intc_r[slwk_pkg::BIT_GIE_LOW] |
                      intc_r[slwk_pkg::BIT_GIE_HIGH];
    assign pin_sink_oe  = armed;
    assign pin_sink_out = 1'b0;
    assign sleeping     = (state_r == slwk_pkg::ST_SLEEP);
    assign wake_pulse   = wake_r;
    assign prog_counter = pc_r;
    assign reg_rdata    = rdata_r;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_nxt = state_r;
        wdog_nxt  = wdog_r;
        intc_nxt  = intc_r;
        preq_nxt  = preq_r | int_req;
        tos_nxt   = tos_r;
        sp_nxt    = sp_r;
        pc_nxt    = pc_r;
        wake_nxt  = 1'b0;
        rdata_nxt = 8'h00;
        if (reg_wr)
        begin
            if (sel(reg_addr, slwk_pkg::ADDR_WDOG_CTRL))
                wdog_nxt = reg_wdata;
            if (sel(reg_addr, slwk_pkg::ADDR_INT_CTRL))
                intc_nxt = reg_wdata;
            if (sel(reg_addr, slwk_pkg::ADDR_PER_REQ))
                preq_nxt = reg_wdata | int_req;
        end
        unique case (state_r)
            slwk_pkg::ST_RUN:
            begin
                if (sleep_cmd)
                    state_nxt = slwk_pkg::ST_SLEEP;
            end
            slwk_pkg::ST_SLEEP:
            begin
                if (pin_wake)
                begin
                    state_nxt = slwk_pkg::ST_RUN;
                    wake_nxt  = 1'b1;
                    pc_nxt    = pc_r + slwk_pkg::PC_STEP;
                    // Set wins over a same-cycle software clear
                    wdog_nxt[slwk_pkg::BIT_WAKE_LVL] = 1'b1;
                end
                else if (int_wake)
                begin
                    state_nxt = slwk_pkg::ST_RUN;
                    wake_nxt  = 1'b1;
                    if (gie_any)
                    begin
                        tos_nxt = pc_r + slwk_pkg::PC_STEP;
                        sp_nxt  = sp_r + 5'h01;
                        pc_nxt  = int_high_prio ? slwk_pkg::VEC_HIGH
                                                : slwk_pkg::VEC_LOW;
                    end
                    else
                        pc_nxt = pc_r + slwk_pkg::PC_STEP;
                end
            end
        endcase
        if (reg_rd)
        begin
            if (sel(reg_addr, slwk_pkg::ADDR_WDOG_CTRL))
                rdata_nxt = wdog_r;
            else if (sel(reg_addr, slwk_pkg::ADDR_INT_CTRL))
                rdata_nxt = intc_r;
            else if (sel(reg_addr, slwk_pkg::ADDR_PER_REQ))
                rdata_nxt = preq_r;
            else if (sel(reg_addr, slwk_pkg::ADDR_STACK_TOP))
                rdata_nxt = tos_r[7:0];
            else if (sel(reg_addr, slwk_pkg::ADDR_STACK_PTR))
                rdata_nxt = {3'b000, sp_r};
            else if (sel(reg_addr, slwk_pkg::ADDR_PC))
                rdata_nxt = pc_r[7:0];
            else if (sel(reg_addr, slwk_pkg::ADDR_STATUS))
                rdata_nxt = {7'h00, sleeping};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= slwk_pkg::ST_RUN;
            wdog_r  <= slwk_pkg::WDOG_RST;
            intc_r  <= slwk_pkg::INT_RST;
            preq_r  <= slwk_pkg::INT_RST;
            tos_r   <= slwk_pkg::PC_RST;
            sp_r    <= slwk_pkg::SP_RST;
            pc_r    <= slwk_pkg::PC_RST;
            wake_r  <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            wdog_r  <= wdog_nxt;
            intc_r  <= intc_nxt;
            preq_r  <= preq_nxt;
            tos_r   <= tos_nxt;
            sp_r    <= sp_nxt;
            pc_r    <= pc_nxt;
            wake_r  <= wake_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sinking only while armed keeps the idle pin current-free
    AST_SINK_WHEN_ARMED: assert property (
        @(posedge sys_clk) disable iff (rst)
        armed |-> pin_sink_oe && !pin_sink_out)
        else $error("Pin not sunk while armed");
    AST_SINK_IDLE: assert property (
        @(posedge sys_clk) disable iff (rst)
        !armed |-> !pin_sink_oe)
        else $error("Pin sunk while not armed");
    AST_PIN_WAKE: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && pin_wake |=> !sleeping && wake_pulse)
        else $error("Pin fall did not wake");
    AST_PIN_WAKE_PC: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && pin_wake
        |=> pc_r == $past(pc_r) + slwk_pkg::PC_STEP)
        else $error("PC not at next instruction");
    AST_WAKE_ONE_CYCLE: assert property (
        @(posedge sys_clk) disable iff (rst)
        wake_pulse |=> !wake_pulse)
        else $error("Wake pulse longer than one cycle");
    AST_LVL_SET: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && pin_wake |=> wdog_r[slwk_pkg::BIT_WAKE_LVL])
        else $error("Wake level flag not set");
    // Only a software write or reset may drop the flag
    AST_LVL_HOLD: assert property (
        @(posedge sys_clk) disable iff (rst)
        wdog_r[slwk_pkg::BIT_WAKE_LVL]
        && !(reg_wr && reg_addr == slwk_pkg::ADDR_WDOG_CTRL)
        |=> wdog_r[slwk_pkg::BIT_WAKE_LVL])
        else $error("Wake level flag lost");
    AST_NO_ARM_NO_WAKE: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && !armed && !int_wake |=> sleeping)
        else $error("Woke with nothing armed");
    AST_STAY_AWAKE: assert property (
        @(posedge sys_clk) disable iff (rst)
        !sleeping && !sleep_cmd |=> !sleeping)
        else $error("Slept without a sleep command");
    // Pushed address is the instruction after the sleep
    AST_INT_PUSH: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && !pin_wake && int_wake && gie_any
        |=> tos_r == $past(pc_r) + slwk_pkg::PC_STEP)
        else $error("Stack top not updated");
    AST_INT_SP: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && !pin_wake && int_wake && gie_any
        |=> sp_r == $past(sp_r) + 5'h01)
        else $error("Stack pointer not advanced");
    AST_INT_VEC: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && !pin_wake && int_wake && gie_any
        |=> pc_r == ($past(int_high_prio) ? slwk_pkg::VEC_HIGH
                                          : slwk_pkg::VEC_LOW))
        else $error("PC not at vector");
    AST_NOGIE_PC: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && !pin_wake && int_wake && !gie_any
        |=> pc_r == $past(pc_r) + slwk_pkg::PC_STEP
            && sp_r == $past(sp_r))
        else $error("Vectored without a global enable");
    AST_REQ_KEPT: assert property (
        @(posedge sys_clk) disable iff (rst)
        sleeping && int_wake
        |=> (preq_r & $past(int_req)) == $past(int_req))
        else $error("Request flag not kept");
    COV_PIN_WAKE: cover property (@(posedge sys_clk) disable iff (rst)
        sleeping && pin_wake);
    COV_INT_VEC: cover property (@(posedge sys_clk) disable iff (rst)
        sleeping && !pin_wake && int_wake && gie_any);
    COV_INT_NOGIE: cover property (@(posedge sys_clk) disable iff (rst)
        sleeping && !pin_wake && int_wake && !gie_any);
    COV_LVL_CLEAR: cover property (@(posedge sys_clk) disable iff (rst)
        wdog_r[slwk_pkg::BIT_WAKE_LVL] && reg_wr
        && reg_addr == slwk_pkg::ADDR_WDOG_CTRL
        && !reg_wdata[slwk_pkg::BIT_WAKE_LVL]);
endmodule
`default_nettype wire

// file: dv/slwk_rc_model.sv
// Behavioural RC network hanging on the wake capacitor pin
`default_nettype none
module slwk_rc_model
#(
    parameter int THRESH = 64,
    parameter int STEP   = 4
)
(
    input  wire logic sys_clk,
    input  wire logic charge,
    input  wire logic pin_sink_oe,
    output logic      pin_below_thresh
);
    timeunit 1ns;
    timeprecision 1ps;
    int level = 0;
    // Software drives the pin high to charge, then releases it
    always @(posedge sys_clk)
        if (charge)
            level <= 255;
        else if (pin_sink_oe && level >= STEP)
            level <= level - STEP;
    // Decay takes many cycles, so the comparator trips late
    assign pin_below_thresh = (level < THRESH);
endmodule
`default_nettype wire

// file: dv/test_slwk_sleep_wake.sv
// Testbench for the sleep wake-up logic
`default_nettype none
module test_slwk_sleep_wake;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        sleep_cmd = 1'b0;
    logic [7:0]  int_req = 8'h00;
    logic        int_high_prio = 1'b0;
    logic        charge = 1'b0;
    logic [7:0]  reg_rdata;
    logic        pin_below_thresh;
    logic        pin_sink_oe;
    logic        pin_sink_out;
    logic        sleeping;
    logic        wake_pulse;
    logic [20:0] prog_counter;
    logic [7:0]  rv;
    int          fail_count = 0;
    int          samples_checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    slwk_sleep_wake u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_cmd(sleep_cmd),
        .pin_below_thresh(pin_below_thresh), .int_req(int_req),
        .int_high_prio(int_high_prio), .pin_sink_oe(pin_sink_oe),
        .pin_sink_out(pin_sink_out), .sleeping(sleeping),
        .wake_pulse(wake_pulse),
        .prog_counter(prog_counter));
    slwk_rc_model u_rc (.sys_clk(sys_clk), .charge(charge),
        .pin_sink_oe(pin_sink_oe), .pin_below_thresh(pin_below_thresh));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [20:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic go_sleep();
        @(posedge sys_clk);
        sleep_cmd <= 1'b1;
        @(posedge sys_clk);
        sleep_cmd <= 1'b0;
        #1 check("sleeping", sleeping, 1'b1);
    endtask
    // Bounded wait for the one-cycle wake pulse
    task automatic wait_wake();
        int n;
        for (n = 0; n < 400 && wake_pulse !== 1'b1; n++)
            @(posedge sys_clk) #1;
        check("wake seen", wake_pulse, 1'b1);
        check("awake", sleeping, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(slwk_pkg::ADDR_WDOG_CTRL, rv);
        check("wdog reset", rv, 8'h00);
        rd(4'h7, rv);
        check("unmapped", rv, 8'h00);
        check("pc reset", prog_counter, slwk_pkg::PC_RST);
        check("awake at reset", sleeping, 1'b0);
        check("no wake at reset", wake_pulse, 1'b0);
        check("no sink at reset", pin_sink_oe, 1'b0);
    endtask
    task automatic t_pin_wake();
        @(posedge sys_clk) charge <= 1'b1;
        @(posedge sys_clk) charge <= 1'b0;
        wr(slwk_pkg::ADDR_WDOG_CTRL, 8'h02);
        #1 check("sink half armed", pin_sink_oe, 1'b0);
        wr(slwk_pkg::ADDR_WDOG_CTRL, 8'h03);
        #1 check("sink armed", pin_sink_oe, 1'b1);
        check("sink level", pin_sink_out, 1'b0);
        go_sleep();
        check("no early wake", wake_pulse, 1'b0);
        wait_wake();
        check("next instr", prog_counter, 21'h00_0002);
        rd(slwk_pkg::ADDR_WDOG_CTRL, rv);
        check("wake flag", rv, 8'h23);
        repeat (5) @(posedge sys_clk);
        rd(slwk_pkg::ADDR_WDOG_CTRL, rv);
        check("flag held", rv, 8'h23);
        wr(slwk_pkg::ADDR_WDOG_CTRL, 8'h00);
        rd(slwk_pkg::ADDR_WDOG_CTRL, rv);
        check("flag cleared", rv, 8'h00);
    endtask
    task automatic t_int_wake(input logic hi, input logic [7:0] gie,
        input logic [20:0] vec, input logic [7:0] sp, tos);
        wr(slwk_pkg::ADDR_INT_CTRL, gie);
        int_high_prio <= hi;
        go_sleep();
        @(posedge sys_clk) int_req <= 8'h01;
        wait_wake();
        @(posedge sys_clk) int_req <= 8'h00;
        check("vector", prog_counter, vec);
        rd(slwk_pkg::ADDR_STACK_PTR, rv);
        check("stack ptr", rv, sp);
        rd(slwk_pkg::ADDR_STACK_TOP, rv);
        check("stack top", rv, tos);
        rd(slwk_pkg::ADDR_PER_REQ, rv);
        check("req flag", rv[0], 1'b1);
        wr(slwk_pkg::ADDR_PER_REQ, 8'h00);
    endtask
    // Without a global enable the core just resumes after the sleep
    task automatic t_int_nogie();
        wr(slwk_pkg::ADDR_INT_CTRL, 8'h00);
        go_sleep();
        @(posedge sys_clk) int_req <= 8'h02;
        wait_wake();
        @(posedge sys_clk) int_req <= 8'h00;
        check("no vector", prog_counter, 21'h00_001A);
        rd(slwk_pkg::ADDR_STACK_PTR, rv);
        check("stack ptr kept", rv, 8'h02);
        rd(slwk_pkg::ADDR_PER_REQ, rv);
        check("req flag 1", rv[1], 1'b1);
        wr(slwk_pkg::ADDR_PER_REQ, 8'h00);
    endtask
    // Reset while asleep, flag set by software, nothing armed
    task automatic t_mid_reset();
        wr(slwk_pkg::ADDR_WDOG_CTRL, 8'h22);
        go_sleep();
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1 check("rst asleep", sleeping, 1'b0);
        check("rst pc", prog_counter, slwk_pkg::PC_RST);
        check("rst sink", pin_sink_oe, 1'b0);
        rd(slwk_pkg::ADDR_WDOG_CTRL, rv);
        check("rst flag", rv, slwk_pkg::WDOG_RST);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_pin_wake();
        // Pushed address is the one after the sleep: pc + 2
        t_int_wake(1'b1, 8'h80, slwk_pkg::VEC_HIGH, 8'h01, 8'h04);
        t_int_wake(1'b0, 8'h40, slwk_pkg::VEC_LOW, 8'h02, 8'h0A);
        t_int_nogie();
        t_mid_reset();
        report_and_stop();
    end
    // Whole run is under two hundred cycles; allow ample margin
    initial
    begin
        #(25ns * 5000);
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
